// ===== verilog/sbt_pkg.sv
// Package of constants and types for the sixteen-bit interval timer.
package sbt_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] ctrl_addr   = 8'h00;
    localparam logic [7:0] count_addr  = 8'h04;
    localparam logic [7:0] period_addr = 8'h08;
    localparam logic [7:0] irq_addr    = 8'h0c;
    localparam logic [7:0] status_addr = 8'h10;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int run_pos      = 15;
    localparam int idle_pos     = 13;
    localparam int gate_pos     = 6;
    localparam int ps_lo_pos    = 4;
    localparam int sync_pos     = 2;
    localparam int src_pos      = 1;
    localparam int ien_pos      = 0;
    localparam int prio_lo_pos  = 4;
    localparam logic [15:0] ctrl_reset   = 16'h0000;
    localparam logic [15:0] period_reset = 16'hffff;
    localparam logic [2:0]  prio_reset   = 3'h4;

    // ------------------------------------------------------------------
    // Prescale codes and divide counts
    // ------------------------------------------------------------------
    localparam logic [1:0] ps_div1   = 2'h0;
    localparam logic [1:0] ps_div8   = 2'h1;
    localparam logic [1:0] ps_div64  = 2'h2;
    localparam logic [1:0] ps_div256 = 2'h3;
    localparam logic [7:0] div1_last   = 8'h00;
    localparam logic [7:0] div8_last   = 8'h07;
    localparam logic [7:0] div64_last  = 8'h3f;
    localparam logic [7:0] div256_last = 8'hff;

    // Counting modes.
    typedef enum logic [1:0] {sbt_mode_timer, sbt_mode_sync, sbt_mode_async} sbt_mode_t;

    // Control fields as one carrier.
    typedef struct packed {
        logic       count_run_bit;
        logic       idle_halt_select;
        logic       gated_accum_enable;
        logic [1:0] prescale_select;
        logic       external_sync_select;
        logic       clock_source_select;
    } sbt_ctrl_t;

    // Interrupt request towards the interrupt controller.
    typedef struct packed {
        logic       req;
        logic [2:0] priority_level;
    } sbt_irq_t;

endpackage

// ===== verilog/sbt_timer.sv
// Sixteen-bit interval timer with APB register access.
//
// Local design decisions: the placing of the registers and the APB register port.

// ------------------------------------------------------------------
// Timer module
// ------------------------------------------------------------------
module sbt_timer (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // External pins and power state
    input  wire logic            external_count_pin,
    input  wire logic            gate_pin,
    input  wire logic            cpu_idle,
    // Interrupt request
    output sbt_pkg::sbt_irq_t    irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Control and period registers as software sees them.
    sbt_pkg::sbt_ctrl_t ctrl, next_ctrl;
    logic [15:0] count, next_count;
    logic [15:0] period_value_reg, next_period;
    logic        timer_irq_enable, next_ien;
    logic [2:0]  timer_irq_priority, next_prio;
    logic        irq_flag, next_irq_flag;
    logic        match_pend, next_match_pend;
    logic [7:0]  prescale, next_prescale;
    // Pin synchroniser chains and edge history.
    logic [1:0]  ext_sync, gate_sync;
    logic [1:0]  next_ext_sync, next_gate_sync;
    logic        ext_prev, gate_prev;
    logic        next_ext_prev, next_gate_prev;
    // Bus decode, read data and the read wait state.
    logic        rd_wait, next_rd_wait;
    logic [31:0] next_prdata;
    logic        wr_acc, rd_acc, addr_ok;
    logic        ext_rise, gate_fall, src_tick, gate_open, count_tick, active;
    sbt_pkg::sbt_mode_t mode;

    // Prescale code to last value of the divider.
    // The divider counts from zero up to this value, so a ratio of n ends at n minus one.
    function automatic logic [7:0] div_last(input logic [1:0] code);
        unique case (code)
            sbt_pkg::ps_div1:   div_last = sbt_pkg::div1_last;
            sbt_pkg::ps_div8:   div_last = sbt_pkg::div8_last;
            sbt_pkg::ps_div64:  div_last = sbt_pkg::div64_last;
            sbt_pkg::ps_div256: div_last = sbt_pkg::div256_last;
        endcase
    endfunction

    // Write strobe of one register. The counter and the register file both decode
    // writes, so they share this helper and cannot disagree on an address.
    function automatic logic wr_hit(input logic       acc,
                                    input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
        wr_hit = acc && (addr == reg_addr);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both pins pass two flops; only the second stage is read further on.
    always_comb begin
        next_ext_sync  = {ext_sync[0], external_count_pin};
        next_gate_sync = {gate_sync[0], gate_pin};
        next_ext_prev  = ext_sync[1];
        next_gate_prev = gate_sync[1];
    end

    // History resets to the idle low level of both pins, so no false edge follows reset.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_sync  <= 2'h0;
            gate_sync <= 2'h0;
            ext_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            ext_sync  <= next_ext_sync;
            gate_sync <= next_gate_sync;
            ext_prev  <= next_ext_prev;
            gate_prev <= next_gate_prev;
        end
    end

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    // With one clock domain the asynchronous mode still samples the pin; it differs
    // from sync mode only in that it keeps counting while the CPU idles with halt set,
    // as a counter on its own pin clock would in Sleep.
    // An external edge reaches the counter three clocks after the pin rises, so pulses
    // must stay high and low for longer than one clock each.
    always_comb begin
        ext_rise  = ext_sync[1] & ~ext_prev;
        gate_fall = ~gate_sync[1] & gate_prev;
        if (!ctrl.clock_source_select) begin
            mode = sbt_pkg::sbt_mode_timer;
        end else if (ctrl.external_sync_select) begin
            mode = sbt_pkg::sbt_mode_sync;
        end else begin
            mode = sbt_pkg::sbt_mode_async;
        end
        src_tick  = (mode == sbt_pkg::sbt_mode_timer) ? 1'b1 : ext_rise;
        // Gate only applies to the internal source.
        gate_open = ctrl.clock_source_select | ~ctrl.gated_accum_enable
                    | gate_sync[1];
        active    = ctrl.count_run_bit
                    & ~(cpu_idle & ctrl.idle_halt_select
                        & (mode != sbt_pkg::sbt_mode_async));
        // The counter advances once per completed prescale interval.
        count_tick = active & src_tick & gate_open
                     & (prescale == div_last(ctrl.prescale_select));
    end

    // ------------------------------------------------------------------
    // Counter, prescaler and interrupt flag
    // ------------------------------------------------------------------
    // A count write wins over a tick in the same cycle, so software reads back what it wrote.
    // The pending-match bit lets the count show the period value for one whole tick
    // before it wraps, instead of skipping it.
    always_comb begin
        next_prescale   = prescale;
        next_count      = count;
        next_match_pend = match_pend;
        next_irq_flag   = irq_flag;
        // A closed gate freezes the prescaler too, so a gated interval resumes where it stopped.
        if (active && src_tick && gate_open) begin
            next_prescale = count_tick ? 8'h00 : 8'(prescale + 8'h01);
        end
        // A stopped timer restarts with a full prescale interval.
        if (!ctrl.count_run_bit) begin
            next_prescale = 8'h00;
        end
        if (count_tick) begin
            if (match_pend) begin
                next_count      = 16'h0000;
                next_match_pend = 1'b0;
            end else begin
                next_count = 16'(count + 16'h0001);
            end
        end
        if (wr_hit(wr_acc, paddr, sbt_pkg::count_addr)) begin
            next_count      = pwdata[15:0];
            next_match_pend = 1'b0;
        end
        // Software clears by writing one to the status bit.
        if (wr_hit(wr_acc, paddr, sbt_pkg::status_addr) && pwdata[0]) begin
            next_irq_flag = 1'b0;
        end
        // A new match or gate event wins over a clear in the same cycle.
        if (count_tick && !match_pend && next_count == period_value_reg) begin
            next_match_pend = 1'b1;
            next_irq_flag   = 1'b1;
        end
        // A gate event is only taken while the timer runs on the internal source.
        if (gate_fall && ctrl.gated_accum_enable && !ctrl.clock_source_select
            && ctrl.count_run_bit) begin
            next_irq_flag = 1'b1;
        end
    end

    // Counter state registers.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prescale   <= 8'h00;
            count      <= 16'h0000;
            match_pend <= 1'b0;
            irq_flag   <= 1'b0;
        end else begin
            prescale   <= next_prescale;
            count      <= next_count;
            match_pend <= next_match_pend;
            irq_flag   <= next_irq_flag;
        end
    end

    // ------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------
    // Writes finish in their first access cycle. Reads take one wait state: the first
    // access cycle loads prdata into its flop, so the data already stands when pready
    // is seen high in the second, at the cost of one cycle per read.
    always_comb begin
        addr_ok = (paddr == sbt_pkg::ctrl_addr) || (paddr == sbt_pkg::count_addr)
                  || (paddr == sbt_pkg::period_addr) || (paddr == sbt_pkg::irq_addr)
                  || (paddr == sbt_pkg::status_addr);
        wr_acc  = psel & penable & pwrite & addr_ok;
        rd_acc  = psel & penable & ~pwrite;
        pready  = ~rd_acc | rd_wait;
        pslverr = psel & penable & ~addr_ok;
        next_rd_wait = rd_acc & ~rd_wait;
    end

    // Register writes and read-data capture; unused bits read back as zero.
    always_comb begin
        next_ctrl   = ctrl;
        next_period = period_value_reg;
        next_ien    = timer_irq_enable;
        next_prio   = timer_irq_priority;
        next_prdata = prdata;
        if (wr_hit(wr_acc, paddr, sbt_pkg::ctrl_addr)) begin
            next_ctrl.count_run_bit        = pwdata[sbt_pkg::run_pos];
            next_ctrl.idle_halt_select     = pwdata[sbt_pkg::idle_pos];
            next_ctrl.gated_accum_enable   = pwdata[sbt_pkg::gate_pos];
            next_ctrl.prescale_select      = pwdata[sbt_pkg::ps_lo_pos +: 2];
            next_ctrl.external_sync_select = pwdata[sbt_pkg::sync_pos];
            next_ctrl.clock_source_select  = pwdata[sbt_pkg::src_pos];
        end
        if (wr_hit(wr_acc, paddr, sbt_pkg::period_addr)) begin
            next_period = pwdata[15:0];
        end
        if (wr_hit(wr_acc, paddr, sbt_pkg::irq_addr)) begin
            next_ien  = pwdata[sbt_pkg::ien_pos];
            next_prio = pwdata[sbt_pkg::prio_lo_pos +: 3];
        end
        // Only the first cycle of a read loads prdata; the wait cycle holds it.
        if (rd_acc && !rd_wait) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                sbt_pkg::ctrl_addr: begin
                    next_prdata[sbt_pkg::run_pos]        = ctrl.count_run_bit;
                    next_prdata[sbt_pkg::idle_pos]       = ctrl.idle_halt_select;
                    next_prdata[sbt_pkg::gate_pos]       = ctrl.gated_accum_enable;
                    next_prdata[sbt_pkg::ps_lo_pos +: 2] = ctrl.prescale_select;
                    next_prdata[sbt_pkg::sync_pos]       = ctrl.external_sync_select;
                    next_prdata[sbt_pkg::src_pos]        = ctrl.clock_source_select;
                end
                sbt_pkg::count_addr:  next_prdata[15:0] = count;
                sbt_pkg::period_addr: next_prdata[15:0] = period_value_reg;
                sbt_pkg::irq_addr: begin
                    next_prdata[sbt_pkg::ien_pos]          = timer_irq_enable;
                    next_prdata[sbt_pkg::prio_lo_pos +: 3] = timer_irq_priority;
                end
                sbt_pkg::status_addr: next_prdata[0] = irq_flag;
                default:              next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file flops; prdata holds between reads.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl               <= sbt_pkg::sbt_ctrl_t'(sbt_pkg::ctrl_reset[6:0]);
            period_value_reg   <= sbt_pkg::period_reset;
            timer_irq_enable   <= 1'b0;
            timer_irq_priority <= sbt_pkg::prio_reset;
            prdata             <= 32'h0000_0000;
            rd_wait            <= 1'b0;
        end else begin
            ctrl               <= next_ctrl;
            period_value_reg   <= next_period;
            timer_irq_enable   <= next_ien;
            timer_irq_priority <= next_prio;
            prdata             <= next_prdata;
            rd_wait            <= next_rd_wait;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // The request is a level that stays until software clears the status bit.
    // Clearing the enable hides it without losing the flag.
    always_comb begin
        irq.req            = irq_flag & timer_irq_enable;
        irq.priority_level = timer_irq_priority;
    end

endmodule

// ===== tb/sbt_monitor.sv
// Port-level checker for the sixteen-bit interval timer.
module sbt_monitor (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    // APB slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Interrupt request
    input wire sbt_pkg::sbt_irq_t irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic acc;
    logic mapped;

    // An access cycle, and whether it hits one of the five registers.
    assign acc    = psel & penable;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_write_ready: assert property (acc && pwrite |-> pready)
        else $error("write access stalled");
    a_read_wait: assert property (acc && !pwrite && !pready |=> pready)
        else $error("read wait state longer than one cycle");
    a_err_unmapped: assert property (pslverr == (acc && !mapped))
        else $error("pslverr wrong for address");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_pad: assert property (acc && !pwrite && mapped |=> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_prio_write: assert property (acc && pwrite && paddr == 8'h0c
        |=> irq.priority_level == $past(pwdata[6:4]))
        else $error("priority not taken from write");
    a_irq_masked: assert property (acc && pwrite && paddr == 8'h0c && !pwdata[0]
        |=> !irq.req [*2])
        else $error("request forwarded while disabled");
    a_irq_hold: assert property (irq.req && !(acc && pwrite) |=> irq.req)
        else $error("request dropped without a write");
    a_reset_quiet: assert property ($rose(reset_n)
        |-> !irq.req && irq.priority_level == 3'h4)
        else $error("interrupt state wrong after reset");
endmodule

// ===== tb/sbt_pin_model.sv
// Far-side model: external count clock and gate level.
module sbt_pin_model (
    // Pins
    output logic ext_pin,
    output logic gate
);
    timeunit 1ns;
    timeprecision 1ns;

    // The count clock rests low outside bursts, as a gated source would.
    initial begin
        ext_pin = 1'h0;
        gate    = 1'h0;
    end

    // Slow, unrelated rate so that the synchroniser sees every rising edge.
    task automatic burst(input int n);
        repeat (n) begin
            #37 ext_pin = 1'h1;
            #41 ext_pin = 1'h0;
        end
    endtask

    // Gate level; a falling step is the gate event.
    task automatic set_gate(input logic v);
        gate <= v;
    endtask
endmodule

// ===== tb/sbt_timer_tb.sv
// Self-checking bench for the sixteen-bit interval timer.
module sbt_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic              sys_clk = 1'h0;
    logic              reset_n = 1'h0;
    logic              psel = 1'h0;
    logic              penable = 1'h0;
    logic              pwrite = 1'h0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              cpu_idle = 1'h0;
    logic              ext_pin;
    logic              gate;
    sbt_pkg::sbt_irq_t irq;
    logic [31:0]       rdat;
    logic              serr;
    int                n_fail = 0;
    int                n_tests = 0;

    // Clock at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    sbt_timer u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(ext_pin), .gate_pin(gate),
        .cpu_idle(cpu_idle), .irq(irq));
    sbt_pin_model u_pins (.ext_pin(ext_pin), .gate(gate));

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; pready, read data and the error flag are taken as they stand
    // at the edge that ends the access phase.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge sys_clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (pready !== 1'h1 && t < 50);
        if (t >= 50) begin
            n_fail++;
            wrap_up();
        end
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask

    // Bounded wait for the interrupt request.
    task automatic wait_irq();
        int t;
        t = 0;
        while (irq.req !== 1'h1 && t < 60) begin
            @(posedge sys_clk);
            t++;
        end
        if (irq.req !== 1'h1) begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic t_reset();
        rd(8'h08);
        chk(rdat, 32'hffff);
        rd(8'h0c);
        chk(rdat, 32'h40);
        rd(8'h00);
        chk(rdat, 32'h0);
        wr(8'h20, 32'h1234);
        chk({31'h0, serr}, 32'h1);
        rd(8'h24);
        chk(rdat, 32'h0);
        chk({31'h0, serr}, 32'h1);
    endtask

    // Run for five prescaled periods plus half of one, or exactly five at divide by one.
    task automatic t_prescale();
        int dv[4] = '{1, 8, 64, 256};
        for (int ps = 0; ps < 4; ps++) begin
            wr(8'h04, 32'h0);
            wr(8'h00, 32'h8000 + 32'(ps) * 32'h10);
            repeat (5 * dv[ps] + dv[ps] / 2 - 3) @(posedge sys_clk);
            wr(8'h00, 32'h0);
            rd(8'h04);
            chk(rdat, 32'h5);
        end
    endtask

    task automatic t_match();
        wr(8'h08, 32'h3);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h51);
        wr(8'h00, 32'h8000);
        wait_irq();
        chk({31'h0, irq.req}, 32'h1);
        chk({29'h0, irq.priority_level}, 32'h5);
        repeat (20) @(posedge sys_clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        chk({31'h0, rdat <= 32'h3}, 32'h1);
        wr(8'h10, 32'h1);
        wr(8'h0c, 32'h50);
    endtask

    // The period is set out of reach so that only the gate can raise the flag.
    task automatic t_gate();
        wr(8'h08, 32'hffff);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h8040);
        repeat (10) @(posedge sys_clk);
        rd(8'h04);
        chk(rdat, 32'h0);
        u_pins.set_gate(1'h1);
        repeat (6) @(posedge sys_clk);
        #1 u_pins.set_gate(1'h0);
        wait_irq();
        chk({31'h0, irq.req}, 32'h1);
        rd(8'h04);
        chk(rdat, 32'h6);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h1);
    endtask

    // External source with the gate closed: the gate must be ignored.
    task automatic t_ext();
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h8046);
        u_pins.burst(7);
        wr(8'h00, 32'h8042);
        u_pins.burst(3);
        repeat (5) @(posedge sys_clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        chk(rdat, 32'ha);
    endtask

    task automatic t_idle();
        cpu_idle <= 1'h1;
        wr(8'h04, 32'h0);
        wr(8'h00, 32'ha000);
        repeat (10) @(posedge sys_clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        chk(rdat, 32'h0);
        wr(8'h00, 32'h8000);
        repeat (2) @(posedge sys_clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        chk(rdat, 32'h5);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'ha002);
        u_pins.burst(2);
        repeat (5) @(posedge sys_clk);
        wr(8'h00, 32'h0);
        rd(8'h04);
        chk(rdat, 32'h2);
        cpu_idle <= 1'h0;
    endtask

    // Reset for five cycles, then the scenarios in turn.
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'h1;
        t_reset();
        t_prescale();
        t_match();
        t_gate();
        t_ext();
        t_idle();
        wrap_up();
    end
endmodule

bind sbt_timer sbt_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
